// >>> design/pmd_top.sv
// How it works
// - set disable bit stops that peripheral's clocks
// - disabled peripheral's register access is blocked
// - enabled needs bit clear and peripheral present
// - all disable bits reset to zero
// - disable takes effect one cycle after write
// - enable one cycle after clear, if configured
// - ctrl1 bits 15..11 disable timers five..one
// - ctrl1 bit 9 disables pwm block
// - ctrl1 bits 7..3 i2c, uarts, spis
// - ctrl1 bit 1 can, bit 0 adc
// - ctrl2 capture bits 11..8, compare 3..0
// - ctrl3 bit 10 disables comparator
// - ctrl4 bit 3 refclk, bit 2 charge timer
// - ctrl6 bits 10..8 disable pwm generators
// - ctrl7 bit 4 disables all dma channels
// - ctrl8 bits 12, 11 sent, 8 deadman
// - unimplemented bits read as zero
`timescale 1ns/1ps
`include "pmd_cfg.svh"

module pmd_top #(
   parameter bit HAS_CAN = 1'b1
) (
   input wire logic i_mclk,                              // system clock, 40 MHz
   input wire logic i_sys_rst,                           // async reset, active high
   input wire logic [`PMD_ADDR_W-1:0] s_axi_awaddr,      // write address
   input wire logic s_axi_awvalid,                       // write address valid
   output logic s_axi_awready,                           // write address ready
   input wire logic [31:0] s_axi_wdata,                  // write data
   input wire logic [3:0] s_axi_wstrb,                   // write byte strobes
   input wire logic s_axi_wvalid,                        // write data valid
   output logic s_axi_wready,                            // write data ready
   output logic [1:0] s_axi_bresp,                       // write response
   output logic s_axi_bvalid,                            // write response valid
   input wire logic s_axi_bready,                        // write response ready
   input wire logic [`PMD_ADDR_W-1:0] s_axi_araddr,      // read address
   input wire logic s_axi_arvalid,                       // read address valid
   output logic s_axi_arready,                           // read address ready
   output logic [31:0] s_axi_rdata,                      // read data
   output logic [1:0] s_axi_rresp,                       // read response
   output logic s_axi_rvalid,                            // read data valid
   input wire logic s_axi_rready,                        // read data ready
   input wire pmd_pkg::pmd_periph_t i_mod_cfg_run,       // peripheral's own control selects operation
   output pmd_pkg::pmd_periph_t o_clk_en,                // clock gate enable per peripheral
   output pmd_pkg::pmd_periph_t o_acc_en,                // csr access enable per peripheral
   output pmd_pkg::pmd_periph_t o_mod_run                // peripheral enabled and configured to run
);

   localparam int NREG = `PMD_NUM_REGS;
   // an absent can unit leaves its bit unimplemented, so it never stores a one
   localparam logic [`PMD_REG_W-1:0] CAN_BIT = {{(`PMD_REG_W-1){1'b0}}, 1'b1} << `PMD_B1_CAN;
   localparam logic [`PMD_REG_W-1:0] CTRL1_MASK = HAS_CAN ? `PMD_MASK_CTRL1 : (`PMD_MASK_CTRL1 & ~CAN_BIT);
   localparam logic [`PMD_REG_W-1:0] MASKS [NREG] = '{CTRL1_MASK, `PMD_MASK_CTRL2, `PMD_MASK_CTRL3,
      `PMD_MASK_CTRL4, `PMD_MASK_CTRL6, `PMD_MASK_CTRL7, `PMD_MASK_CTRL8};

   if (NREG != 7) begin : g_bad_nreg
      $error("pmd_top: register count must be 7");
   end

   // address decode shared by the write and read paths
   function automatic logic [3:0] dec_addr(input logic [`PMD_ADDR_W-1:0] a);
      case (a)
         `PMD_OFF_CTRL1: dec_addr = {1'b1, `PMD_IDX_CTRL1};
         `PMD_OFF_CTRL2: dec_addr = {1'b1, `PMD_IDX_CTRL2};
         `PMD_OFF_CTRL3: dec_addr = {1'b1, `PMD_IDX_CTRL3};
         `PMD_OFF_CTRL4: dec_addr = {1'b1, `PMD_IDX_CTRL4};
         `PMD_OFF_CTRL6: dec_addr = {1'b1, `PMD_IDX_CTRL6};
         `PMD_OFF_CTRL7: dec_addr = {1'b1, `PMD_IDX_CTRL7};
         `PMD_OFF_CTRL8: dec_addr = {1'b1, `PMD_IDX_CTRL8};
         default: dec_addr = 4'h0;
      endcase
   endfunction : dec_addr

   logic [`PMD_REG_W-1:0] dis_q [NREG];
   logic [`PMD_ADDR_W-1:0] awaddr_q;
   logic [`PMD_REG_W-1:0] wdata_q;
   logic [1:0] wstrb_q;
   logic aw_have_q;
   logic w_have_q;
   pmd_pkg::pmd_wr_state_t wr_st_q;
   logic wr_fire;
   logic [3:0] wr_dec;
   logic [3:0] rd_dec;
   pmd_pkg::pmd_periph_t en_d;
   pmd_pkg::pmd_periph_t present;

   // write path: address and data taken in either order
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         aw_have_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         w_have_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         wdata_q <= s_axi_wdata[`PMD_REG_W-1:0];
         wstrb_q <= s_axi_wstrb[1:0];
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end
   end

   assign wr_fire = aw_have_q && w_have_q && (wr_st_q == pmd_pkg::PMD_WR_IDLE);
   assign wr_dec = dec_addr(awaddr_q);

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && (wr_st_q == pmd_pkg::PMD_WR_IDLE);
         s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && (wr_st_q == pmd_pkg::PMD_WR_IDLE);
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_st_q <= pmd_pkg::PMD_WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMD_RESP_OKAY;
      end else begin
         case (wr_st_q)
            pmd_pkg::PMD_WR_IDLE: begin
               if (wr_fire) begin
                  wr_st_q <= pmd_pkg::PMD_WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_dec[3] ? `PMD_RESP_OKAY : `PMD_RESP_SLVERR;
               end
            end
            pmd_pkg::PMD_WR_RESP: begin
               if (s_axi_bready) begin
                  wr_st_q <= pmd_pkg::PMD_WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_st_q <= pmd_pkg::PMD_WR_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // disable registers; unimplemented bits never store a one
   for (genvar g = 0; g < NREG; g++) begin : g_reg
      always_ff @(posedge i_mclk or posedge i_sys_rst) begin
         if (i_sys_rst) begin
            dis_q[g] <= `PMD_RST_VAL;
         end else if (wr_fire && wr_dec[3] && (wr_dec[2:0] == 3'(g))) begin
            dis_q[g] <= {wstrb_q[1] ? wdata_q[15:8] : dis_q[g][15:8],
                         wstrb_q[0] ? wdata_q[7:0] : dis_q[g][7:0]} & MASKS[g];
         end
      end
   end

   // read path, one read at a time
   assign rd_dec = dec_addr(s_axi_araddr);

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `PMD_RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         s_axi_arready <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= rd_dec[3] ? `PMD_RESP_OKAY : `PMD_RESP_SLVERR;
         s_axi_rdata <= rd_dec[3] ? {16'h0000, dis_q[rd_dec[2:0]]} : '0;
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // presence of each peripheral in this variant
   always_comb begin
      present = '1;
      present.can_unit_on = HAS_CAN;
   end

   // bit-to-peripheral mapping
   always_comb begin
      en_d.timers_on = ~dis_q[`PMD_IDX_CTRL1][`PMD_B1_TMR_HI:`PMD_B1_TMR_LO];
      en_d.pwm_block_on = ~dis_q[`PMD_IDX_CTRL1][`PMD_B1_PWM];
      {en_d.i2c_unit_on, en_d.uart_b_on, en_d.uart_a_on, en_d.spi_b_on, en_d.spi_a_on} =
         ~dis_q[`PMD_IDX_CTRL1][`PMD_B1_SER_HI:`PMD_B1_SER_LO];
      en_d.can_unit_on = ~dis_q[`PMD_IDX_CTRL1][`PMD_B1_CAN];
      en_d.adc_unit_on = ~dis_q[`PMD_IDX_CTRL1][`PMD_B1_ADC];
      en_d.capture_on = ~dis_q[`PMD_IDX_CTRL2][`PMD_B2_IC_HI:`PMD_B2_IC_LO];
      en_d.compare_on = ~dis_q[`PMD_IDX_CTRL2][`PMD_B2_OC_HI:`PMD_B2_OC_LO];
      en_d.comparator_on = ~dis_q[`PMD_IDX_CTRL3][`PMD_B3_CMP];
      en_d.refclk_out_on = ~dis_q[`PMD_IDX_CTRL4][`PMD_B4_REFO];
      en_d.charge_timer_on = ~dis_q[`PMD_IDX_CTRL4][`PMD_B4_CTMU];
      en_d.pwm_gen_on = ~dis_q[`PMD_IDX_CTRL6][`PMD_B6_PWMG_HI:`PMD_B6_PWMG_LO];
      en_d.dma_all_on = ~dis_q[`PMD_IDX_CTRL7][`PMD_B7_DMA];
      en_d.sent_b_on = ~dis_q[`PMD_IDX_CTRL8][`PMD_B8_SENTB];
      en_d.sent_a_on = ~dis_q[`PMD_IDX_CTRL8][`PMD_B8_SENTA];
      en_d.deadman_timer_on = ~dis_q[`PMD_IDX_CTRL8][`PMD_B8_DMT];
      en_d = en_d & present;
   end

   // registered enables: one cycle after the register changes, and only on an edge,
   // so a latch-based gate at the peripheral never sees a runt pulse
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_clk_en <= '0;
         o_acc_en <= '0;
         o_mod_run <= '0;
      end else begin
         o_clk_en <= en_d;
         o_acc_en <= en_d;
         o_mod_run <= en_d & i_mod_cfg_run;
      end
   end

   // checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   logic [NREG-1:0] extra_bits;
   logic [NREG-1:0] dis_any;
   always_comb begin
      for (int k = 0; k < NREG; k++) begin
         extra_bits[k] = |(dis_q[k] & ~MASKS[k]);
         dis_any[k] = |dis_q[k];
      end
   end

   unimpl_bits_zero_a: assert property (extra_bits == '0)
      else $error("unimplemented disable bit holds a one");
   gate_tracks_reg_a: assert property (!$past(i_sys_rst) |-> o_clk_en == $past(en_d))
      else $error("clock enable does not follow register after one cycle");
   tmr1_disable_a: assert property (wr_fire && wr_dec == {1'b1, `PMD_IDX_CTRL1} && wstrb_q[1]
      && wdata_q[`PMD_B1_TMR_LO] |-> ##2 !o_clk_en.timers_on[0])
      else $error("timer one still clocked two cycles after disable write");
   access_match_a: assert property (o_acc_en == o_clk_en)
      else $error("access enable differs from clock enable");
   can_absent_a: assert property (!HAS_CAN |-> !o_clk_en.can_unit_on && !o_mod_run.can_unit_on)
      else $error("absent can unit enabled");
   run_needs_en_a: assert property ((o_mod_run & ~o_clk_en) == '0)
      else $error("peripheral runs while clock gated");
   gate_change_cause_a: assert property ($changed(o_clk_en) && !$past(i_sys_rst, 2)
      |-> $past(wr_fire, 2))
      else $error("clock enable changed without a register write");
   dma_single_bit_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.dma_all_on == !$past(dis_q[`PMD_IDX_CTRL7][`PMD_B7_DMA]))
      else $error("dma enable not tied to its bit");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && !rd_dec[3]
      |=> s_axi_rvalid && s_axi_rresp == `PMD_RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read not answered with slave error");


   // every enable equals the inverse of its disable bit one cycle earlier; the can enable does so only when the can unit is present
   timers_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.timers_on == ~$past(dis_q[`PMD_IDX_CTRL1][`PMD_B1_TMR_HI:`PMD_B1_TMR_LO]))
      else $error("timer gates mismatch");
   pwm_block_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.pwm_block_on == !$past(dis_q[`PMD_IDX_CTRL1][`PMD_B1_PWM]))
      else $error("pwm block gate mismatch");
   i2c_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.i2c_unit_on == !$past(dis_q[`PMD_IDX_CTRL1][`PMD_B1_SER_HI]))
      else $error("i2c gate mismatch");
   uart_b_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.uart_b_on == !$past(dis_q[`PMD_IDX_CTRL1][`PMD_B1_SER_HI-1]))
      else $error("uart b gate mismatch");
   uart_a_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.uart_a_on == !$past(dis_q[`PMD_IDX_CTRL1][`PMD_B1_SER_HI-2]))
      else $error("uart a gate mismatch");
   spi_b_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.spi_b_on == !$past(dis_q[`PMD_IDX_CTRL1][`PMD_B1_SER_LO+1]))
      else $error("spi b gate mismatch");
   spi_a_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.spi_a_on == !$past(dis_q[`PMD_IDX_CTRL1][`PMD_B1_SER_LO]))
      else $error("spi a gate mismatch");
   can_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.can_unit_on == (HAS_CAN && !$past(dis_q[`PMD_IDX_CTRL1][`PMD_B1_CAN])))
      else $error("can gate mismatch");
   adc_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.adc_unit_on == !$past(dis_q[`PMD_IDX_CTRL1][`PMD_B1_ADC]))
      else $error("adc gate mismatch");
   capture1_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.capture_on[0] == !$past(dis_q[`PMD_IDX_CTRL2][`PMD_B2_IC_LO]))
      else $error("capture 1 gate mismatch");
   capture2_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.capture_on[1] == !$past(dis_q[`PMD_IDX_CTRL2][`PMD_B2_IC_LO+1]))
      else $error("capture 2 gate mismatch");
   capture3_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.capture_on[2] == !$past(dis_q[`PMD_IDX_CTRL2][`PMD_B2_IC_LO+2]))
      else $error("capture 3 gate mismatch");
   capture4_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.capture_on[3] == !$past(dis_q[`PMD_IDX_CTRL2][`PMD_B2_IC_HI]))
      else $error("capture 4 gate mismatch");
   compare1_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.compare_on[0] == !$past(dis_q[`PMD_IDX_CTRL2][`PMD_B2_OC_LO]))
      else $error("compare 1 gate mismatch");
   compare2_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.compare_on[1] == !$past(dis_q[`PMD_IDX_CTRL2][`PMD_B2_OC_LO+1]))
      else $error("compare 2 gate mismatch");
   compare3_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.compare_on[2] == !$past(dis_q[`PMD_IDX_CTRL2][`PMD_B2_OC_LO+2]))
      else $error("compare 3 gate mismatch");
   compare4_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.compare_on[3] == !$past(dis_q[`PMD_IDX_CTRL2][`PMD_B2_OC_HI]))
      else $error("compare 4 gate mismatch");
   comparator_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.comparator_on == !$past(dis_q[`PMD_IDX_CTRL3][`PMD_B3_CMP]))
      else $error("comparator gate mismatch");
   refclk_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.refclk_out_on == !$past(dis_q[`PMD_IDX_CTRL4][`PMD_B4_REFO]))
      else $error("refclk gate mismatch");
   charge_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.charge_timer_on == !$past(dis_q[`PMD_IDX_CTRL4][`PMD_B4_CTMU]))
      else $error("charge timer gate mismatch");
   pwm_gen1_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.pwm_gen_on[0] == !$past(dis_q[`PMD_IDX_CTRL6][`PMD_B6_PWMG_LO]))
      else $error("pwm generator 1 gate mismatch");
   pwm_gen2_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.pwm_gen_on[1] == !$past(dis_q[`PMD_IDX_CTRL6][`PMD_B6_PWMG_LO+1]))
      else $error("pwm generator 2 gate mismatch");
   pwm_gen3_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.pwm_gen_on[2] == !$past(dis_q[`PMD_IDX_CTRL6][`PMD_B6_PWMG_HI]))
      else $error("pwm generator 3 gate mismatch");
   sent_b_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.sent_b_on == !$past(dis_q[`PMD_IDX_CTRL8][`PMD_B8_SENTB]))
      else $error("sent b gate mismatch");
   sent_a_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.sent_a_on == !$past(dis_q[`PMD_IDX_CTRL8][`PMD_B8_SENTA]))
      else $error("sent a gate mismatch");
   deadman_map_a: assert property (!$past(i_sys_rst) |->
      o_clk_en.deadman_timer_on == !$past(dis_q[`PMD_IDX_CTRL8][`PMD_B8_DMT]))
      else $error("deadman timer gate mismatch");

   reset_clears_a: assert property ($past(i_sys_rst) |-> dis_any == '0)
      else $error("disable register not zero after reset");
   acc_tracks_reg_a: assert property (!$past(i_sys_rst) |-> o_acc_en == $past(en_d))
      else $error("access enable does not follow register after one cycle");
   run_tracks_cfg_a: assert property (!$past(i_sys_rst) |->
      o_mod_run == ($past(en_d) & $past(i_mod_cfg_run)))
      else $error("run enable does not follow enable and configuration");
   wr_answer_a: assert property (wr_fire |=> s_axi_bvalid)
      else $error("write not answered after commit");
   wr_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel ready while response pending");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered one cycle after address");
   rd_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address ready while data pending");

   write_seen_c: cover property (wr_fire && wr_dec[3]);
   read_seen_c: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == `PMD_RESP_OKAY);
   bad_addr_c: cover property (wr_fire && !wr_dec[3]);
   disable_seen_c: cover property ($fell(o_clk_en.adc_unit_on) ##[1:20] $rose(o_clk_en.adc_unit_on));
   partial_strobe_c: cover property (wr_fire && wr_dec[3] && wstrb_q != 2'b11);

endmodule : pmd_top

// >>> design/pmd_cfg.svh
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH

// register count and byte offsets of the disable registers
`define PMD_NUM_REGS 7
`define PMD_REG_W 16
`define PMD_OFF_CTRL1 12'h000
`define PMD_OFF_CTRL2 12'h004
`define PMD_OFF_CTRL3 12'h008
`define PMD_OFF_CTRL4 12'h00C
`define PMD_OFF_CTRL6 12'h010
`define PMD_OFF_CTRL7 12'h014
`define PMD_OFF_CTRL8 12'h018

// implemented-bit masks, everything else reads zero
`define PMD_MASK_CTRL1 16'hFAFB
`define PMD_MASK_CTRL2 16'h0F0F
`define PMD_MASK_CTRL3 16'h0400
`define PMD_MASK_CTRL4 16'h000C
`define PMD_MASK_CTRL6 16'h0700
`define PMD_MASK_CTRL7 16'h0010
`define PMD_MASK_CTRL8 16'h1900
`define PMD_RST_VAL 16'h0000

// register indices
`define PMD_IDX_CTRL1 3'h0
`define PMD_IDX_CTRL2 3'h1
`define PMD_IDX_CTRL3 3'h2
`define PMD_IDX_CTRL4 3'h3
`define PMD_IDX_CTRL6 3'h4
`define PMD_IDX_CTRL7 3'h5
`define PMD_IDX_CTRL8 3'h6

// field positions
`define PMD_B1_TMR_HI 15
`define PMD_B1_TMR_LO 11
`define PMD_B1_PWM 9
`define PMD_B1_SER_HI 7
`define PMD_B1_SER_LO 3
`define PMD_B1_CAN 1
`define PMD_B1_ADC 0
`define PMD_B2_IC_HI 11
`define PMD_B2_IC_LO 8
`define PMD_B2_OC_HI 3
`define PMD_B2_OC_LO 0
`define PMD_B3_CMP 10
`define PMD_B4_REFO 3
`define PMD_B4_CTMU 2
`define PMD_B6_PWMG_HI 10
`define PMD_B6_PWMG_LO 8
`define PMD_B7_DMA 4
`define PMD_B8_SENTB 12
`define PMD_B8_SENTA 11
`define PMD_B8_DMT 8

// bus answers
`define PMD_RESP_OKAY 2'h0
`define PMD_RESP_SLVERR 2'h2
`define PMD_ADDR_W 12

`endif

// >>> design/pmd_pkg.sv
package pmd_pkg;

   // one bit per gated peripheral, high means enabled
   typedef struct packed {
      logic [4:0] timers_on;     // timer5..timer1
      logic pwm_block_on;
      logic i2c_unit_on;
      logic uart_b_on;
      logic uart_a_on;
      logic spi_b_on;
      logic spi_a_on;
      logic can_unit_on;
      logic adc_unit_on;
      logic [3:0] capture_on;    // unit4..unit1
      logic [3:0] compare_on;    // unit4..unit1
      logic comparator_on;
      logic refclk_out_on;
      logic charge_timer_on;
      logic [2:0] pwm_gen_on;    // gen3..gen1
      logic dma_all_on;
      logic sent_b_on;
      logic sent_a_on;
      logic deadman_timer_on;
   } pmd_periph_t;

   typedef enum logic [1:0] {
      PMD_WR_IDLE = 2'b00,
      PMD_WR_RESP = 2'b01
   } pmd_wr_state_t;

endpackage : pmd_pkg

// >>> verification/pmd_periph_model.sv
`timescale 1ns/1ps
module pmd_periph_model (
   input wire logic i_mclk,                       // system clock
   input wire logic i_sys_rst,                    // async reset, active high
   input wire pmd_pkg::pmd_periph_t i_clk_en,     // gated clock enables
   input wire pmd_pkg::pmd_periph_t i_acc_en,     // csr access enables
   input wire pmd_pkg::pmd_periph_t i_cfg_want,   // control value software writes
   output pmd_pkg::pmd_periph_t o_cfg_run         // own control selects operation
);
   // a peripheral's control bit only takes a write while clocked and reachable
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_cfg_run <= '0;
      end else begin
         o_cfg_run <= (i_cfg_want & i_acc_en & i_clk_en) | (o_cfg_run & ~(i_acc_en & i_clk_en));
      end
   end
endmodule : pmd_periph_model

// >>> verification/pmd_bench.sv
`timescale 1ns/1ps
module pmd_bench;
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   pmd_pkg::pmd_periph_t clk_en, acc_en, mod_run, cfg_run, nc_clk_en;
   pmd_pkg::pmd_periph_t cfg_want = '1;
   logic [15:0] shadow [7];
   logic [15:0] mask [7];
   int n_errors = 0;
   int samples_checked = 0;

   always #12.5 i_mclk = ~i_mclk;

   pmd_top #(.HAS_CAN(1'b1)) pmd_top_i (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .i_mod_cfg_run(cfg_run), .o_clk_en(clk_en), .o_acc_en(acc_en), .o_mod_run(mod_run)
   );

   // variant without the can unit, fed the same bus traffic
   pmd_top #(.HAS_CAN(1'b0)) pmd_top_nocan_i (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(),
      .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(),
      .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b1),
      .i_mod_cfg_run(cfg_run), .o_clk_en(nc_clk_en), .o_acc_en(), .o_mod_run()
   );

   pmd_periph_model pmd_periph_model_i (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
      .i_acc_en(acc_en), .i_cfg_want(cfg_want), .o_cfg_run(cfg_run)
   );

   function automatic pmd_pkg::pmd_periph_t exp_en();
      return ~{shadow[0][15:11], shadow[0][9], shadow[0][7:3], shadow[0][1:0],
         shadow[1][11:8], shadow[1][3:0], shadow[2][10], shadow[3][3:2],
         shadow[4][10:8], shadow[5][4], shadow[6][12:11], shadow[6][8]};
   endfunction : exp_en

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic axi_wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
      @(posedge i_mclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge i_mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      #1;
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_mclk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge i_mclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      #1;
   endtask : axi_rd

   task automatic wr_reg(input int idx, input logic [15:0] v, input logic [3:0] s);
      logic [1:0] r;
      axi_wr(12'(idx * 4), v, s, r);
      if (s[0]) shadow[idx][7:0] = v[7:0] & mask[idx][7:0];
      if (s[1]) shadow[idx][15:8] = v[15:8] & mask[idx][15:8];
      check({1'b0, clk_en}, {1'b0, exp_en()});
      check({1'b0, acc_en}, {1'b0, exp_en()});
      check({1'b0, nc_clk_en}, {1'b0, exp_en()} & 32'h7FF7FFFF);
      check({30'h0, r}, 32'h00000000);
   endtask : wr_reg

   task automatic rd_reg(input int idx);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(12'(idx * 4), d, r);
      check({30'h0, r}, 32'h00000000);
      check(d, {16'h0000, shadow[idx]});
   endtask : rd_reg

   task automatic t_reset();
      for (int i = 0; i < 7; i++) rd_reg(i);
      check({1'b0, clk_en}, 32'h7FFFFFFF);
      check({1'b0, nc_clk_en}, 32'h7FF7FFFF);
   endtask : t_reset

   // reset in mid-run wipes every disable bit
   task automatic t_midreset();
      wr_reg(0, 16'hFFFF, 4'h3);
      wr_reg(6, 16'hFFFF, 4'h3);
      @(posedge i_mclk);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      #1;
      check({1'b0, clk_en}, 32'h00000000);
      @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      shadow = '{default: 16'h0000};
      t_reset();
   endtask : t_midreset

   // walk a single one through every position, unimplemented ones included
   task automatic t_bits();
      for (int i = 0; i < 7; i++) begin
         wr_reg(i, 16'hFFFF, 4'h3);
         rd_reg(i);
         for (int b = 0; b < 16; b++) begin
            wr_reg(i, 16'h0001 << b, 4'h3);
            rd_reg(i);
         end
         wr_reg(i, 16'h0000, 4'h3);
      end
   endtask : t_bits

   task automatic t_strobe();
      wr_reg(0, 16'hFFFF, 4'h1);
      rd_reg(0);
      wr_reg(0, 16'hFFFF, 4'h2);
      rd_reg(0);
      wr_reg(0, 16'h0000, 4'h1);
      rd_reg(0);
      wr_reg(0, 16'h0000, 4'hE);
      rd_reg(0);
   endtask : t_strobe

   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(12'h01C, 16'hFFFF, 4'hF, r);
      check({30'h0, r}, 32'h00000002);
      check({1'b0, clk_en}, 32'h7FFFFFFF);
      axi_rd(12'h01C, d, r);
      check({30'h0, r}, 32'h00000002);
      check(d, 32'h00000000);
   endtask : t_unmapped

   task automatic t_run();
      repeat (2) @(posedge i_mclk);
      #1;
      check({31'h0, mod_run.dma_all_on}, 32'h00000001);
      wr_reg(5, 16'h0010, 4'h3);
      @(posedge i_mclk);
      #1;
      check({31'h0, mod_run.dma_all_on}, 32'h00000000);
      @(posedge i_mclk);
      cfg_want.dma_all_on <= 1'b0;
      repeat (3) @(posedge i_mclk);
      #1;
      check({31'h0, cfg_run.dma_all_on}, 32'h00000001);
      @(posedge i_mclk);
      cfg_want.dma_all_on <= 1'b1;
      wr_reg(5, 16'h0000, 4'h3);
      @(posedge i_mclk);
      #1;
      check({31'h0, mod_run.dma_all_on}, 32'h00000001);
      @(posedge i_mclk);
      cfg_want.dma_all_on <= 1'b0;
      repeat (3) @(posedge i_mclk);
      #1;
      check({31'h0, mod_run.dma_all_on}, 32'h00000000);
   endtask : t_run

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   initial begin
      mask = '{16'hFAFB, 16'h0F0F, 16'h0400, 16'h000C, 16'h0700, 16'h0010, 16'h1900};
      shadow = '{default: 16'h0000};
      repeat (2) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      t_reset();
      t_bits();
      t_strobe();
      t_unmapped();
      t_midreset();
      t_run();
      wrap_up();
   end

   initial begin
      repeat (30000) @(posedge i_mclk);
      n_errors++;
      wrap_up();
   end
endmodule : pmd_bench
